// File: rtl/port_ctrl_regs.svh
// Constants for one synchronous dual-port RAM access port.
// Assumes inclusion by bare name from the design files under rtl/ and from the bench checker.
`ifndef PORT_CTRL_REGS_SVH
`define PORT_CTRL_REGS_SVH

// Array geometry
`define PORT_ADDR_WIDTH 15
`define PORT_DATA_WIDTH 36
`define PORT_LANES 4
`define PORT_LANE_WIDTH 9

// Latency mode select codes
`define LATENCY_FLOW 1'b0
`define LATENCY_PIPE 1'b1

// Reset values
`define COUNTER_RESET_VALUE 15'h0000

`endif

// File: rtl/port_ctrl_pkg.sv
// Types shared by the access port design.
// Assumes nothing of its surroundings.
package port_ctrl_pkg;

    // Output path state, one-hot
    typedef enum logic [2:0] {
        OUT_IDLE = 3'b001,
        OUT_WAKE = 3'b010,
        OUT_LIVE = 3'b100
    } out_state_type;

    // Address source for one access
    typedef enum logic [1:0] {
        ADDR_FROM_PINS = 2'b01,
        ADDR_FROM_COUNTER = 2'b10
    } addr_source_type;

endpackage

// File: rtl/burst_counter.sv
// Burst address counter with clear, load and increment.
// Assumes inputs synchronous to clock; clear has the highest priority.
`timescale 1ns/1ps
`include "port_ctrl_regs.svh"

module burst_counter #(
    parameter int ADDR_WIDTH = `PORT_ADDR_WIDTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic counter_clear_n,
    input wire logic load,
    input wire logic increment,
    input wire logic [ADDR_WIDTH-1:0] load_value,
    // State
    output logic [ADDR_WIDTH-1:0] count
);

    ////////////////////////////////////////////////////////////////////////
    // Counter state
    logic [ADDR_WIDTH-1:0] count_q; // Current burst address
    logic [ADDR_WIDTH-1:0] count_d; // Next burst address

    // Next count: clear wins, then load, then increment
    always_comb begin
        count_d = count_q;
        if (!counter_clear_n) begin
            count_d = '0; // see R6, see R7
        end else if (load) begin
            count_d = load_value; // see R2
        end else if (increment) begin
            count_d = count_q + 1'b1; // see R4, see R13
        end
    end

    // Register the count; rising edges only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d; // see R12
        end
    end

    assign count = count_q;

endmodule

// File: rtl/byte_lane_ram.sv
// Byte-lane memory array with synchronous write and combinational read.
// Assumes one clock; a lane whose enable is low is neither written nor read.
`timescale 1ns/1ps
`include "port_ctrl_regs.svh"

module byte_lane_ram #(
    parameter int ADDR_WIDTH = `PORT_ADDR_WIDTH,
    parameter int LANES = `PORT_LANES,
    parameter int LANE_WIDTH = `PORT_LANE_WIDTH
) (
    // Clock
    input wire logic clock,
    // Access
    input wire logic [ADDR_WIDTH-1:0] address,
    input wire logic write,
    input wire logic [LANES-1:0] lane_enable,
    input wire logic [LANES*LANE_WIDTH-1:0] write_data,
    // Read word, disabled lanes zero
    output logic [LANES*LANE_WIDTH-1:0] read_data
);

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [LANES*LANE_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1]; // Array words

    // Write enabled lanes only
    always_ff @(posedge clock) begin
        for (int i = 0; i < LANES; i++) begin
            if (write && lane_enable[i]) begin
                mem[address][i*LANE_WIDTH +: LANE_WIDTH] <= write_data[i*LANE_WIDTH +: LANE_WIDTH]; // see R11
            end
        end
    end

    // Read enabled lanes only
    always_comb begin
        read_data = '0;
        for (int i = 0; i < LANES; i++) begin
            if (lane_enable[i]) begin
                read_data[i*LANE_WIDTH +: LANE_WIDTH] = mem[address][i*LANE_WIDTH +: LANE_WIDTH]; // see R11
            end
        end
    end

endmodule

// File: rtl/dual_port_sram_port_ctrl.sv
// One access port of a synchronous dual-port RAM, left-port style.
// Assumes a bus master drives the pins synchronously to clock; the data
// pins are split into input, output and output enable.
//
// Function
// R1 - Strobe low uses address pins for access
// R2 - Counter loads when strobe and enable low
// R3 - Clear low makes strobe ignored
// R4 - Enable low advances counter every edge
// R5 - Clear low makes enable ignored
// R6 - Clear low sets counter to zero
// R7 - Clear wins over strobe and enable
// R8 - Data driven on read only with output enable
// R9 - Write-not-read low writes, high reads
// R10 - Mode low flow-through, high pipelined
// R11 - Byte lanes gate reads and writes
// R12 - Works with free-running or gated clock
// R13 - Counter wraps from top to zero
// R14 - Pipelined needs one selected cycle to reactivate
// R15 - Pipelined data one cycle later
`timescale 1ns/1ps
`include "port_ctrl_regs.svh"

module dual_port_sram_port_ctrl #(
    parameter int ADDR_WIDTH = `PORT_ADDR_WIDTH,
    parameter int LANES = `PORT_LANES,
    parameter int LANE_WIDTH = `PORT_LANE_WIDTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Address and burst control
    input wire logic [ADDR_WIDTH-1:0] address,
    input wire logic address_strobe_n,
    input wire logic count_enable_n,
    input wire logic counter_clear_n,
    // Access control
    input wire logic chip_enable_n,
    input wire logic write_not_read,
    input wire logic output_enable_n,
    input wire logic latency_mode_select,
    input wire logic [LANES-1:0] byte_lane_select_n,
    // Data pins
    input wire logic [LANES*LANE_WIDTH-1:0] data_in,
    output logic [LANES*LANE_WIDTH-1:0] data_out,
    output logic [LANES*LANE_WIDTH-1:0] data_oe,
    // Burst counter state
    output logic [ADDR_WIDTH-1:0] burst_address
);

    localparam int DW = LANES * LANE_WIDTH;

    ////////////////////////////////////////////////////////////////////////
    // Address selection

    port_ctrl_pkg::addr_source_type addr_source; // Where this access points
    logic [ADDR_WIDTH-1:0] count; // Counter value
    logic [ADDR_WIDTH-1:0] access_address; // Address used now
    logic strobe_taken; // Strobe accepted this edge
    logic load; // Counter load
    logic increment; // Counter advance

    // Strobe and enable are masked while clear is low
    always_comb begin
        strobe_taken = counter_clear_n && !address_strobe_n; // see R3
        load = strobe_taken && !count_enable_n; // see R2
        increment = counter_clear_n && !count_enable_n; // see R5
        if (strobe_taken) begin
            addr_source = port_ctrl_pkg::ADDR_FROM_PINS; // see R1
        end else begin
            addr_source = port_ctrl_pkg::ADDR_FROM_COUNTER;
        end
        unique case (addr_source)
            port_ctrl_pkg::ADDR_FROM_PINS: begin
                access_address = address;
            end
            port_ctrl_pkg::ADDR_FROM_COUNTER: begin
                access_address = count;
            end
        endcase
    end

    // Burst counter, clear first
    burst_counter #(
        .ADDR_WIDTH(ADDR_WIDTH)
    ) counter_inst (
        .clock(clock),
        .rst_n(rst_n),
        .counter_clear_n(counter_clear_n),
        .load(load),
        .increment(increment),
        .load_value(address),
        .count(count)
    );

    assign burst_address = count;

    ////////////////////////////////////////////////////////////////////////
    // Memory array

    logic access_write; // Write this edge
    logic [LANES-1:0] lane_enable; // Active-high lanes
    logic [DW-1:0] array_data; // Lane-gated read word

    // Write when selected and write-not-read low
    always_comb begin
        access_write = !chip_enable_n && !write_not_read; // see R9
        lane_enable = ~byte_lane_select_n; // see R11
    end

    byte_lane_ram #(
        .ADDR_WIDTH(ADDR_WIDTH),
        .LANES(LANES),
        .LANE_WIDTH(LANE_WIDTH)
    ) ram_inst (
        .clock(clock),
        .address(access_address),
        .write(access_write),
        .lane_enable(lane_enable),
        .write_data(data_in),
        .read_data(array_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read stages

    logic [DW-1:0] flow_q; // Flow-through read word
    logic [DW-1:0] flow_d;
    logic [LANES-1:0] flow_lanes_q; // Lanes read, flow stage
    logic [LANES-1:0] flow_lanes_d;
    logic flow_read_q; // Read captured, flow stage
    logic flow_read_d;
    logic [DW-1:0] pipe_q; // Pipelined output register
    logic [DW-1:0] pipe_d;
    logic [LANES-1:0] pipe_lanes_q; // Lanes read, pipe stage
    logic [LANES-1:0] pipe_lanes_d;
    logic pipe_read_q; // Read captured, pipe stage
    logic pipe_read_d;

    // Flow stage takes the array; pipe stage adds one cycle
    always_comb begin
        flow_read_d = !chip_enable_n && write_not_read; // see R9
        flow_d = flow_read_d ? array_data : flow_q;
        flow_lanes_d = flow_read_d ? lane_enable : '0; // see R11
        pipe_d = flow_q; // see R15
        pipe_lanes_d = flow_lanes_q;
        pipe_read_d = flow_read_q;
    end

    // Register both stages
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flow_q <= '0;
            flow_lanes_q <= '0;
            flow_read_q <= 1'b0;
            pipe_q <= '0;
            pipe_lanes_q <= '0;
            pipe_read_q <= 1'b0;
        end else begin
            flow_q <= flow_d;
            flow_lanes_q <= flow_lanes_d;
            flow_read_q <= flow_read_d;
            pipe_q <= pipe_d;
            pipe_lanes_q <= pipe_lanes_d;
            pipe_read_q <= pipe_read_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pipelined output wake-up

    port_ctrl_pkg::out_state_type out_q; // Output path state
    port_ctrl_pkg::out_state_type out_d;

    // Deselect idles; a selected cycle wakes; the next is live
    always_comb begin
        out_d = out_q;
        unique case (out_q)
            port_ctrl_pkg::OUT_IDLE: begin
                if (!chip_enable_n) begin
                    out_d = port_ctrl_pkg::OUT_WAKE; // see R14
                end
            end
            port_ctrl_pkg::OUT_WAKE: begin
                out_d = chip_enable_n ? port_ctrl_pkg::OUT_IDLE : port_ctrl_pkg::OUT_LIVE;
            end
            port_ctrl_pkg::OUT_LIVE: begin
                if (chip_enable_n) begin
                    out_d = port_ctrl_pkg::OUT_IDLE;
                end
            end
            default: begin
                out_d = port_ctrl_pkg::OUT_IDLE;
            end
        endcase
    end

    // Register the wake state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_q <= port_ctrl_pkg::OUT_IDLE;
        end else begin
            out_q <= out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pin drive

    logic [DW-1:0] drive_d; // Output enable per bit
    logic [DW-1:0] word_sel; // Word on the pins
    logic [LANES-1:0] lanes_sel; // Lanes that were read
    logic read_sel; // A read is presented
    logic path_live; // Output path awake

    // Pick the stage by mode, gate by output enable and lanes
    always_comb begin
        if (latency_mode_select == `LATENCY_PIPE) begin
            word_sel = pipe_q; // see R10, see R15
            lanes_sel = pipe_lanes_q;
            read_sel = pipe_read_q;
            path_live = (out_q == port_ctrl_pkg::OUT_LIVE); // see R14
        end else begin
            word_sel = flow_q; // see R10
            lanes_sel = flow_lanes_q;
            read_sel = flow_read_q;
            path_live = 1'b1;
        end
        drive_d = '0;
        for (int i = 0; i < LANES; i++) begin
            if (!output_enable_n && read_sel && path_live && lanes_sel[i]) begin
                drive_d[i*LANE_WIDTH +: LANE_WIDTH] = '1; // see R8, see R11
            end
        end
    end

    assign data_out = word_sel;
    assign data_oe = drive_d;

endmodule

// File: bench/bus_master_model.sv
// Bus master view of the shared data wires of the port.
// Assumes the master never drives the wires while the port drives them.
`timescale 1ns/1ps
module bus_master_model (
    // Port side
    input wire logic clock,
    input wire logic [35:0] data_out,
    input wire logic [35:0] data_oe,
    // Level seen on the wires
    output logic [35:0] bus_level
);
    logic [35:0] last_q = 36'h0; // Last level seen
    // Released bits invert every cycle, so a stale word never passes
    assign bus_level = (data_out & data_oe) | (~last_q & ~data_oe);
    // Remember the level at every edge
    always @(posedge clock) last_q <= bus_level;
endmodule

// File: bench/dual_port_sram_port_ctrl_properties.sv
// Pin-level checks of one access port.
// Assumes binding to the port top with its own geometry.
`timescale 1ns/1ps
`include "port_ctrl_regs.svh"
module dual_port_sram_port_ctrl_properties #(
    parameter int ADDR_WIDTH = `PORT_ADDR_WIDTH,
    parameter int LANES = `PORT_LANES,
    parameter int LANE_WIDTH = `PORT_LANE_WIDTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control pins
    input wire logic [ADDR_WIDTH-1:0] address,
    input wire logic address_strobe_n,
    input wire logic count_enable_n,
    input wire logic counter_clear_n,
    input wire logic chip_enable_n,
    input wire logic write_not_read,
    input wire logic output_enable_n,
    input wire logic latency_mode_select,
    input wire logic [LANES-1:0] byte_lane_select_n,
    // Data and counter
    input wire logic [LANES*LANE_WIDTH-1:0] data_in,
    input wire logic [LANES*LANE_WIDTH-1:0] data_out,
    input wire logic [LANES*LANE_WIDTH-1:0] data_oe,
    input wire logic [ADDR_WIDTH-1:0] burst_address
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    chk_clear_zeroes: assert property (!counter_clear_n |=> burst_address == '0)
        else $error("counter not cleared");
    chk_strobe_load: assert property (counter_clear_n && !address_strobe_n && !count_enable_n
        |=> burst_address == $past(address)) else $error("counter not loaded");
    chk_count_step: assert property (counter_clear_n && address_strobe_n && !count_enable_n
        |=> burst_address == $past(burst_address) + 1'b1) else $error("counter not stepped");
    chk_count_hold: assert property (counter_clear_n && count_enable_n |=> $stable(burst_address))
        else $error("counter moved");
    chk_oe_gate: assert property (output_enable_n |-> data_oe == '0) else $error("drive without enable");
    chk_write_quiet: assert property (!latency_mode_select && !chip_enable_n && !write_not_read
        ##1 !latency_mode_select |-> data_oe == '0) else $error("drive after write");
    chk_flow_drive: assert property (!latency_mode_select && !chip_enable_n && write_not_read
        && byte_lane_select_n == '0 ##1 !latency_mode_select && !output_enable_n |-> data_oe == '1)
        else $error("flow read not driven");
    chk_pipe_wake: assert property (latency_mode_select && chip_enable_n ##1 latency_mode_select
        && !chip_enable_n |=> data_oe == '0) else $error("pipe woke early");
    chk_pipe_drive: assert property (latency_mode_select && !chip_enable_n && write_not_read
        && byte_lane_select_n == '0 ##1 latency_mode_select && !chip_enable_n
        ##1 latency_mode_select && !output_enable_n |-> data_oe == '1) else $error("pipe read lost");
endmodule

// File: bench/tb_dual_port_sram_port_ctrl.sv
// Self-checking bench of one access port.
// Assumes the port top, the bus master model and the pin checker.
`timescale 1ns/1ps
module tb_dual_port_sram_port_ctrl;
    // Stimulus and observation
    logic clock = 0, rst_n = 0, address_strobe_n = 1, count_enable_n = 1, counter_clear_n = 1;
    logic chip_enable_n = 1, write_not_read = 1, output_enable_n = 0, latency_mode_select = 0;
    logic [14:0] address = 15'h0;
    logic [3:0] byte_lane_select_n = 4'hf;
    logic [35:0] data_in = 36'h0, data_out, data_oe, bus_level;
    logic [14:0] burst_address;
    int miscompares = 0, check_count = 0;
    localparam logic [35:0] WORD = 36'h1_2345_67ff; // Word after the lane-0 overwrite
    dual_port_sram_port_ctrl i_dual_port_sram_port_ctrl (.clock, .rst_n, .address, .address_strobe_n,
        .count_enable_n, .counter_clear_n, .chip_enable_n, .write_not_read, .output_enable_n,
        .latency_mode_select, .byte_lane_select_n, .data_in, .data_out, .data_oe, .burst_address);
    bus_master_model i_bus_master_model (.clock, .data_out, .data_oe, .bus_level);
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////
    // One cycle: ctl is {chip_enable_n, write_not_read, address_strobe_n, count_enable_n}
    task automatic op(input logic [3:0] ctl, input logic [14:0] a, input logic [35:0] d, input logic [3:0] l);
        {chip_enable_n, write_not_read, address_strobe_n, count_enable_n} = ctl;
        address = a;
        data_in = d;
        byte_lane_select_n = l;
        @(posedge clock);
        #1;
    endtask
    // Compare and count
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Verdict
    task automatic results;
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Clear against strobe and enable, load, step and wrap
    task automatic s_counter;
        counter_clear_n = 0;
        op(4'b1100, 15'h1234, 36'h0, 4'hf);
        chk({21'h0, burst_address}, 36'h0);
        counter_clear_n = 1;
        op(4'b1100, 15'h7ffe, 36'h0, 4'hf);
        chk({21'h0, burst_address}, 36'h0_0000_7ffe);
        op(4'b1110, 15'h0, 36'h0, 4'hf);
        op(4'b1110, 15'h0, 36'h0, 4'hf);
        chk({21'h0, burst_address}, 36'h0);
        op(4'b1101, 15'h0555, 36'h0, 4'hf);
        chk({21'h0, burst_address}, 36'h0);
    endtask
    // Flow-through writes and reads with lane gating
    task automatic s_flow;
        latency_mode_select = 0;
        op(4'b0001, 15'h0040, 36'h1_2345_6789, 4'h0);
        op(4'b0001, 15'h0040, 36'hf_ffff_ffff, 4'he);
        op(4'b0101, 15'h0040, 36'h0, 4'h0);
        chk(bus_level, WORD);
        op(4'b0101, 15'h0040, 36'h0, 4'he);
        chk(data_oe, 36'h0_0000_01ff);
        output_enable_n = 1;
        #1;
        chk(data_oe, 36'h0);
        output_enable_n = 0;
        op(4'b0001, 15'h0041, 36'h0, 4'h0);
        chk(data_oe, 36'h0);
    endtask
    // Pipelined reads after a deselect, first from pins then from the counter
    task automatic s_pipe;
        latency_mode_select = 1;
        op(4'b1101, 15'h0, 36'h0, 4'h0);
        op(4'b0100, 15'h0040, 36'h0, 4'h0);
        chk(data_oe, 36'h0);
        op(4'b0110, 15'h0, 36'h0, 4'h0);
        chk(bus_level, WORD);
        // Stay selected so the live output path shows the counter read
        op(4'b0111, 15'h0, 36'h0, 4'h0);
        chk(bus_level, WORD);
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence with reset held five cycles
    initial begin
        repeat (5) @(posedge clock);
        #1;
        rst_n = 1;
        s_counter();
        s_flow();
        s_pipe();
        results();
    end
    // Hang guard
    initial begin
        #100000;
        miscompares++;
        results();
    end
endmodule
bind dual_port_sram_port_ctrl dual_port_sram_port_ctrl_properties #(.ADDR_WIDTH(ADDR_WIDTH), .LANES(LANES),
    .LANE_WIDTH(LANE_WIDTH)) i_dual_port_sram_port_ctrl_properties (.clock, .rst_n, .address, .address_strobe_n,
    .count_enable_n, .counter_clear_n, .chip_enable_n, .write_not_read, .output_enable_n, .latency_mode_select,
    .byte_lane_select_n, .data_in, .data_out, .data_oe, .burst_address);
